// ### core/mch_front_end.sv
// Multichannel address filter, line framing and status byte front end
//
// Contract
// - Stored address limited to 1 through 30.
// - New address applies only on confirm.
// - Selected unit executes unaddressed messages.
// - Explicit address overrides current selection.
// - Select command moves selection between units.
// - Broadcast select clears every unit selection.
// - Single-addressed unit always answers.
// - Otherwise only selected unit answers.
// - Execute when own address is included.
// - Host-attached unit forwards messages to bus.
// - Bit 2 shows error queue non-empty.
// - Bit 3 shows questionable summary.
// - Bit 4 shows output data available.
// - Bit 5 shows standard event summary.
// - Bit 6 carries master summary flag.
// - Bit 7 shows operation summary.
// - Status query leaves status unchanged.
// - Master summary is masked OR, skip 6.
// - CR ends message, LF bytes dropped.
module mch_front_end
  import mch_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  // Operator address entry
  input wire logic [4:0] addrEntry,
  input wire logic addrConfirm,
  output logic [4:0] unitAddress,
  // Received byte stream from the host interface
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  output logic [7:0] lineByte,
  output logic lineValid,
  output logic lineEnd,
  // Parsed header of the current message
  input wire logic hdrValid,
  input msg_hdr_t hdr,
  output logic execStrobe,
  output logic respondEnable,
  output logic selected,
  // Forwarding to the RS-485 bus
  input wire logic hostAttached,
  input wire logic fwdReady,
  output logic [7:0] fwdByte,
  output logic fwdValid,
  // Status sources and enable access
  input status_src_t statusSrc,
  input wire logic sreWrite,
  input wire logic [7:0] sreData,
  output logic [7:0] sreValue,
  input wire logic stbQuery,
  output logic [7:0] serviceSummaryByte,
  output logic masterSummaryFlag,
  output logic [7:0] stbReply,
  output logic stbReplyValid
);

  // Stored multichannel address
  logic [4:0] addr_r;
  // Selected state of this unit
  logic selected_r;
  // Verdict for current header
  msg_verdict_t verdict;
  // Own address bit within a unit mask
  logic ownInMask;
  // Framing outputs
  logic [7:0] lineByte_r;
  logic lineValid_r;
  logic lineEnd_r;
  // Forwarding outputs
  logic [7:0] fwdByte_r;
  logic fwdValid_r;
  // Verdict outputs
  logic execStrobe_r;
  logic respond_r;
  // Status reply outputs
  logic [7:0] stbReply_r;
  logic stbReplyValid_r;
  // Live status byte from submodule
  logic [7:0] liveByte;
  // Front panel entry, first synchroniser stage
  logic [4:0] entryMeta_r;
  // Front panel entry, second stage
  logic [4:0] entrySync_r;
  // Front panel entry, third stage
  logic [4:0] entryLate_r;
  // Settled entry once stages two and three agree
  logic [4:0] entryClean_r;
  // Confirm control, first stage
  logic confMeta_r;
  // Confirm control, second stage
  logic confSync_r;
  // Confirm control, third stage
  logic confLate_r;
  // Settled confirm level
  logic confClean_r;
  // Settled confirm one cycle back
  logic confPrev_r;
  // One-cycle commit pulse per confirm press
  logic commitPulse;
  // Settled entry lies within 1 through 30
  logic entryInRange;
  // Select command names the broadcast address
  logic selBroadcast;
  // Select command names this unit
  logic selOwn;

  // Front panel controls are asynchronous to mclk.
  // Three stages keep metastability off the address register,
  // and a value counts only when two stages agree.

  // Shift the address entry through three stages
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      entryMeta_r <= 5'h00;
      entrySync_r <= 5'h00;
      entryLate_r <= 5'h00;
    end else begin
      entryMeta_r <= addrEntry;
      entrySync_r <= entryMeta_r;
      entryLate_r <= entrySync_r;
    end
  end

  // Shift the confirm control through three stages
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      confMeta_r <= 1'b0;
      confSync_r <= 1'b0;
      confLate_r <= 1'b0;
    end else begin
      confMeta_r <= addrConfirm;
      confSync_r <= confMeta_r;
      confLate_r <= confSync_r;
    end
  end

  // Accept a new level only when stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      entryClean_r <= 5'h00;
      confClean_r <= 1'b0;
      confPrev_r <= 1'b0;
    end else begin
      // Settled entry value
      if (entrySync_r == entryLate_r) begin
        entryClean_r <= entryLate_r;
      end
      // Settled confirm level
      if (confSync_r == confLate_r) begin
        confClean_r <= confLate_r;
      end
      // Previous level for press detection
      confPrev_r <= confClean_r;
    end
  end

  // Commit once per press; a held control does not repeat
  assign commitPulse = confClean_r && !confPrev_r;
  assign entryInRange = (entryClean_r >= ADDR_MIN) && (entryClean_r <= ADDR_MAX);

  // Decode of the select command target
  assign selBroadcast = (hdr.selectAddr == ADDR_BCAST);
  assign selOwn = (hdr.selectAddr == addr_r);

  // Address register: commit only in-range entries
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_r <= ADDR_RESET;
    end else if (commitPulse) begin
      if (entryInRange) begin
        addr_r <= entryClean_r;
      end
    end
  end

  // Selection state follows select commands
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      selected_r <= 1'b0;
    end else if (hdrValid && hdr.isSelect) begin
      if (selBroadcast) begin
        selected_r <= 1'b0;
      end else begin
        selected_r <= selOwn;
      end
    end
  end

  // Own bit lookup in the unit mask
  assign ownInMask = hdr.unitMask[addr_r];

  // Execute and respond decision
  always_comb begin
    verdict.execute = 1'b0;
    verdict.respond = 1'b0;
    case (hdr.kind)
      ADR_NONE: begin
        verdict.execute = selected_r;
        verdict.respond = selected_r;
      end
      ADR_SINGLE: begin
        verdict.execute = ownInMask;
        verdict.respond = ownInMask;
      end
      ADR_LIST: begin
        verdict.execute = ownInMask;
        verdict.respond = selected_r;
      end
      ADR_ALL: begin
        verdict.execute = 1'b1;
        verdict.respond = selected_r;
      end
      default: begin
        verdict.execute = 1'b0;
        verdict.respond = 1'b0;
      end
    endcase
  end

  // Register verdict per header; respond level held until the next header
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      execStrobe_r <= 1'b0;
      respond_r <= 1'b0;
    end else begin
      execStrobe_r <= hdrValid && verdict.execute;
      if (hdrValid) begin
        respond_r <= verdict.respond;
      end
    end
  end

  // Line framing of received bytes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lineByte_r <= 8'h00;
      lineValid_r <= 1'b0;
      lineEnd_r <= 1'b0;
    end else begin
      lineValid_r <= 1'b0;
      lineEnd_r <= 1'b0;
      if (rxValid) begin
        if (rxByte == BYTE_CR) begin
          lineEnd_r <= 1'b1;
        end else if (rxByte != BYTE_LF) begin
          lineByte_r <= rxByte;
          lineValid_r <= 1'b1;
        end
      end
    end
  end

  // Forward received bytes to the serial bus
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fwdByte_r <= 8'h00;
      fwdValid_r <= 1'b0;
    end else begin
      if (rxValid && hostAttached) begin
        fwdByte_r <= rxByte;
        fwdValid_r <= 1'b1;
      end else if (fwdReady) begin
        fwdValid_r <= 1'b0;
      end
    end
  end

  // Status byte assembly
  status_byte u_status (
    .mclk(mclk),
    .rst_n(rst_n),
    .src(statusSrc),
    .sreWrite(sreWrite),
    .sreData(sreData),
    .sreValue(sreValue),
    .serviceSummaryByte(liveByte),
    .masterSummaryFlag(masterSummaryFlag)
  );

  // Status query reply: a copy, no side effects
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stbReply_r <= 8'h00;
      stbReplyValid_r <= 1'b0;
    end else begin
      stbReplyValid_r <= stbQuery;
      if (stbQuery) begin
        stbReply_r <= liveByte & 8'hfc;
      end
    end
  end

  // Output drives
  assign unitAddress = addr_r;
  assign selected = selected_r;
  assign execStrobe = execStrobe_r;
  assign respondEnable = respond_r;
  assign lineByte = lineByte_r;
  assign lineValid = lineValid_r;
  assign lineEnd = lineEnd_r;
  assign fwdByte = fwdByte_r;
  assign fwdValid = fwdValid_r;
  assign serviceSummaryByte = liveByte;
  assign stbReply = stbReply_r;
  assign stbReplyValid = stbReplyValid_r;

endmodule

// ### core/mch_pkg.sv
// Package: shared constants and carrier types for the multichannel front end
package mch_pkg;

  // Address range and broadcast value
  localparam logic [4:0] ADDR_MIN = 5'h01;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [4:0] ADDR_BCAST = 5'h00;
  localparam logic [4:0] ADDR_RESET = 5'h01;
  localparam int NUM_UNITS = 31;

  // Line framing bytes
  localparam logic [7:0] BYTE_CR = 8'h0d;
  localparam logic [7:0] BYTE_LF = 8'h0a;

  // Status byte field positions
  localparam int SB_ERRQ = 2;
  localparam int SB_QUES = 3;
  localparam int SB_MAV = 4;
  localparam int SB_ESB = 5;
  localparam int SB_MSS = 6;
  localparam int SB_OPER = 7;
  localparam logic [7:0] SRE_RESET = 8'h00;

  // Kind of addressing carried by a message header
  typedef enum logic [1:0] {
    ADR_NONE,
    ADR_SINGLE,
    ADR_LIST,
    ADR_ALL
  } addr_kind_t;

  // Parsed message header from the command parser
  typedef struct packed {
    addr_kind_t kind;
    logic [NUM_UNITS-1:0] unitMask;
    logic isSelect;
    logic [4:0] selectAddr;
  } msg_hdr_t;

  // Decision for one message
  typedef struct packed {
    logic execute;
    logic respond;
  } msg_verdict_t;

  // Summary inputs to the status byte
  typedef struct packed {
    logic errQueueNotEmpty;
    logic questionableSummary;
    logic outputDataAvailable;
    logic standardEventSummary;
    logic operationSummary;
  } status_src_t;

endpackage

// ### core/status_byte.sv
// Status byte assembly and master summary computation
module status_byte
  import mch_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input status_src_t src,
  input wire logic sreWrite,
  input wire logic [7:0] sreData,
  output logic [7:0] sreValue,
  output logic [7:0] serviceSummaryByte,
  output logic masterSummaryFlag
);

  // Service request enable register
  logic [7:0] sre_r;
  // Raw status bits without bit 6
  logic [7:0] rawByte;

  // Enable register write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sre_r <= SRE_RESET;
    end else if (sreWrite) begin
      sre_r <= sreData;
    end
  end

  // Assemble raw bits; low two bits tied to zero
  always_comb begin
    rawByte = 8'h00;
    rawByte[SB_ERRQ] = src.errQueueNotEmpty;
    rawByte[SB_QUES] = src.questionableSummary;
    rawByte[SB_MAV] = src.outputDataAvailable;
    rawByte[SB_ESB] = src.standardEventSummary;
    rawByte[SB_OPER] = src.operationSummary;
  end

  // Registered outputs; reads never disturb these
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      serviceSummaryByte <= 8'h00;
      masterSummaryFlag <= 1'b0;
    end else begin
      masterSummaryFlag <= |(rawByte & sre_r & 8'hbf);
      serviceSummaryByte <= rawByte | {1'b0, |(rawByte & sre_r & 8'hbf), 6'h00};
    end
  end

  assign sreValue = sre_r;

endmodule

// ### verif/mch_front_end_sva.sv
// Checker bound to the multichannel front end ports
module mch_front_end_sva
  import mch_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [4:0] addrEntry,
  input wire logic addrConfirm,
  input wire logic [4:0] unitAddress,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  input wire logic lineValid,
  input wire logic lineEnd,
  input wire logic hdrValid,
  input msg_hdr_t hdr,
  input wire logic execStrobe,
  input wire logic respondEnable,
  input wire logic selected,
  input wire logic hostAttached,
  input wire logic [7:0] fwdByte,
  input wire logic fwdValid,
  input status_src_t statusSrc,
  input wire logic [7:0] serviceSummaryByte,
  input wire logic stbQuery,
  input wire logic stbReplyValid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  addr_keep_a: assert property (
    $changed(unitAddress) |-> unitAddress inside {[ADDR_MIN:ADDR_MAX]}) else $error("address out of range");
  addr_take_a: assert property (
    $rose(addrConfirm) ##1 (addrConfirm && $stable(addrEntry)) [*2] ##0 addrEntry inside {[ADDR_MIN:ADDR_MAX]}
    |-> ##3 unitAddress == $past(addrEntry, 3)) else $error("address not taken");
  bcast_clear_a: assert property (
    hdrValid && hdr.isSelect && hdr.selectAddr == ADDR_BCAST |=> !selected) else $error("select kept");
  unaddr_exec_a: assert property (
    hdrValid && hdr.kind == ADR_NONE |=> execStrobe == $past(selected) && respondEnable == $past(selected))
    else $error("unaddressed verdict");
  single_resp_a: assert property (
    hdrValid && hdr.kind == ADR_SINGLE |=> respondEnable == $past(hdr.unitMask[unitAddress]))
    else $error("single verdict");
  lf_drop_a: assert property (
    rxValid && rxByte == BYTE_LF |=> !lineValid && !lineEnd) else $error("line feed passed");
  cr_end_a: assert property (
    rxValid && rxByte == BYTE_CR |=> lineEnd) else $error("no line end");
  sum_bits_a: assert property (
    $past(rst_n) |-> {serviceSummaryByte[2], serviceSummaryByte[3], serviceSummaryByte[4], serviceSummaryByte[5],
    serviceSummaryByte[7], serviceSummaryByte[1:0]} == {$past(statusSrc), 2'h0}) else $error("summary bits");
  fwd_copy_a: assert property (
    rxValid && hostAttached |=> fwdValid && fwdByte == $past(rxByte)) else $error("byte not forwarded");
  query_reply_a: assert property (
    stbQuery |=> stbReplyValid) else $error("no status reply");
  cover property (hdrValid && hdr.isSelect);
  cover property (stbQuery);
  cover property (lineEnd);
endmodule

bind mch_front_end mch_front_end_sva chk (.*);

// ### verif/fwd_sink.sv
// Sibling unit model draining forwarded bytes
module fwd_sink (
  input wire logic mclk,
  input wire logic fwdValid,
  output logic fwdReady,
  output int nGot
);
  timeunit 1ns;
  timeprecision 1ns;
  int stall = 0;
  initial fwdReady = 1'h0;
  initial nGot = 0;
  // Ready after a random stall of 0 to 2 cycles
  always @(negedge mclk) begin
    if (fwdReady || !fwdValid) fwdReady <= 1'h0;
    else if (stall > 0) stall--;
    else begin
      fwdReady <= 1'h1;
      nGot++;
      stall = $urandom % 3;
    end
  end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the multichannel front end
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench
  import mch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0, rst_n = 1'h0, addrConfirm = 1'h0, rxValid = 1'h0, hdrValid = 1'h0;
  logic hostAttached = 1'h0, sreWrite = 1'h0, stbQuery = 1'h0;
  logic lineValid, lineEnd, execStrobe, respondEnable, selected, fwdReady, fwdValid, masterSummaryFlag, stbReplyValid;
  logic [4:0] addrEntry = 5'h0, unitAddress, own, oth;
  logic [7:0] rxByte = 8'h0, sreData = 8'h0, lineByte, fwdByte, sreValue, serviceSummaryByte, stbReply, expB, expS;
  logic [30:0] m, o;
  msg_hdr_t hdr = '0;
  status_src_t statusSrc = '0;
  logic [7:0] lineQ[$], stbQ[$];
  int n_errors = 0, compares = 0, cyc = 0, nGot, nSent = 0;
  mch_front_end DUT (.*);
  fwd_sink sink (.mclk(mclk), .fwdValid(fwdValid), .fwdReady(fwdReady), .nGot(nGot));
  always #20 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      summarize();
    end
  end
  // Match line and reply outputs against the oldest notes
  always @(negedge mclk) begin
    if (lineValid || lineEnd) begin
      expB = lineQ.size() ? lineQ.pop_front() : 8'hxx;
      `CHK("lineEnd", expB == BYTE_CR, lineEnd)
      if (!lineEnd) `CHK("lineByte", expB, lineByte)
    end
    if (stbReplyValid) begin
      expB = stbQ.size() ? stbQ.pop_front() : 8'hxx;
      `CHK("stbReply", expB, stbReply)
    end
  end
  task automatic summarize();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic setAddr(logic [4:0] a, logic [4:0] e);
    @(negedge mclk);
    addrEntry = a;
    addrConfirm = 1'h1;
    repeat (3) @(negedge mclk);
    addrConfirm = 1'h0;
    addrEntry = ~a;
    repeat (5) @(negedge mclk);
    `CHK("unitAddress", e, unitAddress)
  endtask
  task automatic hdrTx(addr_kind_t k, logic [30:0] u, logic s, logic [4:0] a, logic ex, logic rs, logic sl);
    @(negedge mclk);
    hdr = '{k, u, s, a};
    hdrValid = 1'h1;
    @(negedge mclk);
    hdrValid = 1'h0;
    `CHK("execStrobe", ex, execStrobe)
    `CHK("respondEnable", rs, respondEnable)
    `CHK("selected", sl, selected)
  endtask
  task automatic rxTx(logic [7:0] b);
    @(negedge mclk);
    rxByte = b;
    rxValid = 1'h1;
    if (b != BYTE_LF) lineQ.push_back(b);
    nSent += hostAttached;
    @(negedge mclk);
    rxValid = 1'h0;
    repeat (6) @(negedge mclk);
  endtask
  initial begin
    void'($urandom(96));
    repeat (6) @(negedge mclk);
    rst_n = 1'h1;
    `CHK("unitAddress", ADDR_RESET, unitAddress)
    own = 5'(1 + $urandom % 30);
    oth = (own == ADDR_MAX) ? ADDR_MIN : own + 5'h1;
    m = 31'h1 << own;
    o = 31'h1 << oth;
    setAddr(5'h0, ADDR_RESET);
    setAddr(5'h1f, ADDR_RESET);
    setAddr(ADDR_MAX, ADDR_MAX);
    setAddr(own, own);
    $display("address test done");
    hdrTx(ADR_NONE, 31'h0, 1'h0, 5'h0, 1'h0, 1'h0, 1'h0);
    hdrTx(ADR_NONE, 31'h0, 1'h1, own, 1'h0, 1'h0, 1'h1);
    hdrTx(ADR_NONE, 31'h0, 1'h0, 5'h0, 1'h1, 1'h1, 1'h1);
    hdrTx(ADR_SINGLE, o, 1'h0, 5'h0, 1'h0, 1'h0, 1'h1);
    hdrTx(ADR_LIST, m | o, 1'h0, 5'h0, 1'h1, 1'h1, 1'h1);
    hdrTx(ADR_ALL, 31'h0, 1'h0, 5'h0, 1'h1, 1'h1, 1'h1);
    hdrTx(ADR_NONE, 31'h0, 1'h1, oth, 1'h1, 1'h1, 1'h0);
    hdrTx(ADR_SINGLE, m, 1'h0, 5'h0, 1'h1, 1'h1, 1'h0);
    hdrTx(ADR_LIST, o, 1'h0, 5'h0, 1'h0, 1'h0, 1'h0);
    hdrTx(ADR_ALL, 31'h0, 1'h0, 5'h0, 1'h1, 1'h0, 1'h0);
    hdrTx(ADR_NONE, 31'h0, 1'h1, own, 1'h0, 1'h0, 1'h1);
    hdrTx(ADR_NONE, 31'h0, 1'h1, ADDR_BCAST, 1'h1, 1'h1, 1'h0);
    $display("header test done");
    hostAttached = 1'h1;
    repeat (5) rxTx(8'h20 + 8'($urandom % 80));
    rxTx(BYTE_LF);
    rxTx(BYTE_CR);
    hostAttached = 1'h0;
    rxTx(8'h41);
    `CHK("forwarded", nSent, nGot)
    $display("framing test done");
    repeat (8) begin
      @(negedge mclk);
      statusSrc = status_src_t'($urandom);
      sreData = 8'($urandom);
      sreWrite = 1'h1;
      @(negedge mclk);
      sreWrite = 1'h0;
      repeat (3) @(negedge mclk);
      expS = {statusSrc[0], 1'h0, statusSrc[1], statusSrc[2], statusSrc[3], statusSrc[4], 2'h0};
      expS[6] = |(expS & sreData & 8'hbf);
      `CHK("sreValue", sreData, sreValue)
      `CHK("summaryByte", expS, serviceSummaryByte)
      `CHK("masterFlag", expS[6], masterSummaryFlag)
      stbQ.push_back(expS);
      stbQuery = 1'h1;
      @(negedge mclk);
      stbQuery = 1'h0;
      @(negedge mclk);
      `CHK("summaryKept", expS, serviceSummaryByte)
    end
    $display("status test done");
    summarize();
  end
endmodule
